//--- logic/wocr_top.sv
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module wocr_top #(
    parameter int NUM_CORES = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [wocr_pkg::CMD_W-1:0] cmd_data,
    input wire logic [NUM_CORES-1:0] trig_in,
    input wire logic [NUM_CORES*2*wocr_pkg::SMP_W-1:0] line_smp,
    output logic [NUM_CORES-1:0] core_playing,
    output logic [NUM_CORES*2*wocr_pkg::SMP_W-1:0] wave_out
);
    import wocr_pkg::*;

    generate
        if (NUM_CORES != 2 && NUM_CORES != MAX_CORES) begin : g_bad_cores
            $error("wocr_top: NUM_CORES must be 2 or 4");
        end
    endgenerate

    localparam int NL = 2 * NUM_CORES;

    logic [1:0] grouping_reg;
    logic [GAIN_W-1:0] gain_reg [NL];
    logic [15:0] drops_reg;
    wocr_gstate_t gstate_reg [NUM_CORES];
    logic [LEN_W-1:0] cnt_reg [NUM_CORES];
    logic [NUM_CORES-1:0] trig_s1_reg;
    logic [NUM_CORES-1:0] trig_s2_reg;
    logic [NUM_CORES-1:0] trig_s3_reg;
    logic [NUM_CORES-1:0] trig_lvl_reg;
    logic [NUM_CORES-1:0] trig_rise;
    logic [NUM_CORES-1:0] busy;
    logic [NUM_CORES-1:0] waiting;

    logic [CMD_W-1:0] head;
    logic head_valid;
    logic head_ready;
    logic [1:0] head_grp;
    logic [LEN_W-1:0] head_len;
    logic head_wait;
    logic [2:0] n_groups;
    logic grp_ok;
    logic accept;

    // Bus state
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] dp_addr_reg;
    logic addr_phase;
    logic [31:0] rd_val;

    function automatic logic [1:0] grp_of(input int c, input logic [1:0] m);
        if (m == GRP_1X8) begin
            return 2'h0;
        end else if (m == GRP_2X4) begin
            return 2'(c / 2);
        end
        return 2'(c);
    endfunction

    wocr_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_cmd_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_data),
        .out_valid(head_valid),
        .out_ready(head_ready),
        .out_data(head)
    );

    assign head_grp = head[C_GRP +: 2];
    assign head_len = head[C_LEN +: LEN_W];
    assign head_wait = head[C_WAIT];

    always_comb begin
        case (grouping_reg)
            GRP_1X8: n_groups = 3'h1;
            GRP_2X4: n_groups = 3'(NUM_CORES / 2);
            default: n_groups = 3'(NUM_CORES);
        endcase
    end

    assign grp_ok = {1'b0, head_grp} < n_groups;
    // A command waits until its own group is idle; bad groups are dropped
    assign head_ready = !grp_ok || (gstate_reg[head_grp] == G_IDLE);
    assign accept = head_valid && head_ready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drops_reg <= '0;
        end else if (accept && !grp_ok) begin
            drops_reg <= drops_reg + 16'h0001;
        end
    end

    // Trigger pins: three stages, a change counts when stages 2 and 3 agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_s1_reg <= '0;
            trig_s2_reg <= '0;
            trig_s3_reg <= '0;
            trig_lvl_reg <= '0;
        end else begin
            trig_s1_reg <= trig_in;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
            for (int i = 0; i < NUM_CORES; i++) begin
                if (trig_s2_reg[i] == trig_s3_reg[i]) begin
                    trig_lvl_reg[i] <= trig_s3_reg[i];
                end
            end
        end
    end

    assign trig_rise = trig_s2_reg & trig_s3_reg & ~trig_lvl_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_CORES; g++) begin : g_grp
            logic start;
            assign start = accept && grp_ok && head_grp == 2'(g) &&
                           head_len != '0;
            assign busy[g] = gstate_reg[g] != G_IDLE;
            assign waiting[g] = gstate_reg[g] == G_WAIT;

            // Each group sequences and triggers on its own
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    gstate_reg[g] <= G_IDLE;
                    cnt_reg[g] <= '0;
                end else begin
                    case (gstate_reg[g])
                        G_IDLE: begin
                            if (start) begin
                                cnt_reg[g] <= head_len;
                                gstate_reg[g] <= head_wait ? G_WAIT : G_PLAY;
                            end
                        end
                        G_WAIT: begin
                            if (trig_rise[g]) begin
                                gstate_reg[g] <= G_PLAY;
                            end
                        end
                        G_PLAY: begin
                            cnt_reg[g] <= cnt_reg[g] - 1'b1;
                            if (cnt_reg[g] == LEN_W'(1)) begin
                                gstate_reg[g] <= G_IDLE;
                            end
                        end
                        default: gstate_reg[g] <= G_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < NUM_CORES; c++) begin : g_core
            logic [ROUTE_W-1:0] route_reg;
            logic [1:0] my_grp;
            logic active;
            logic [1:0] sel1;
            logic [1:0] sel2;
            logic [1:0] m1;
            logic [1:0] m2;

            assign my_grp = grp_of(c, grouping_reg);
            assign active = gstate_reg[my_grp] == G_PLAY;
            assign core_playing[c] = active;

            // All cores of a group latch their slice on the same accept
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    route_reg <= '0;
                end else if (accept && grp_ok && head_grp == my_grp) begin
                    route_reg <= head[C_ROUTE + c * ROUTE_W +: ROUTE_W];
                end
            end

            // Selectors are pair-local masks, so no other pair is reachable
            assign sel1 = route_reg[R_W1_SEL +: 2];
            assign sel2 = route_reg[R_W2_SEL +: 2];

            always_comb begin
                m1 = SEL_NONE;
                m2 = SEL_NONE;
                if (active && route_reg[R_W1_PRES]) begin
                    m1 = (sel1 == SEL_NONE) ? SEL_A : sel1;
                end
                if (active && route_reg[R_W2_PRES]) begin
                    m2 = (sel2 == SEL_NONE) ? SEL_B : sel2;
                end
            end

            wocr_core_router u_router (
                .hclk(hclk),
                .hresetn(hresetn),
                .l1_smp(line_smp[(2*c)*SMP_W +: SMP_W]),
                .l2_smp(line_smp[(2*c+1)*SMP_W +: SMP_W]),
                .l1_gain(gain_reg[2*c]),
                .l2_gain(gain_reg[2*c+1]),
                .l1_mask(m1),
                .l2_mask(m2),
                .out_a(wave_out[(2*c)*SMP_W +: SMP_W]),
                .out_b(wave_out[(2*c+1)*SMP_W +: SMP_W])
            );
        end
    endgenerate

    // AHB-Lite slave: writes zero-wait, reads one wait state
    assign addr_phase = hsel && htrans[1] && hready;
    assign hreadyout = !rd_pend_reg;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            dp_addr_reg <= '0;
        end else begin
            if (hready) begin
                wr_pend_reg <= addr_phase && hwrite;
                rd_pend_reg <= addr_phase && !hwrite;
                dp_addr_reg <= haddr[7:0];
            end else begin
                rd_pend_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_val = '0;
        if (dp_addr_reg == A_GROUPING) begin
            rd_val[1:0] = grouping_reg;
        end else if (dp_addr_reg == A_STATUS) begin
            rd_val[NUM_CORES-1:0] = busy;
            rd_val[ST_WAIT_POS +: NUM_CORES] = waiting;
            rd_val[ST_GRP_POS +: 2] = grouping_reg;
        end else if (dp_addr_reg == A_DROPS) begin
            rd_val[15:0] = drops_reg;
        end else begin
            for (int i = 0; i < NL; i++) begin
                if (dp_addr_reg == A_GAIN_BASE + 8'(4 * i)) begin
                    rd_val[GAIN_W-1:0] = gain_reg[i];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_pend_reg) begin
            hrdata <= rd_val;
        end
    end

    // Grouping changes only while every group is idle; code 3 is ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grouping_reg <= GRP_RESET;
        end else if (wr_pend_reg && dp_addr_reg == A_GROUPING &&
                     busy == '0 && hwdata[1:0] != 2'h3) begin
            grouping_reg <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NL; i++) begin
                gain_reg[i] <= GAIN_RESET;
            end
        end else if (wr_pend_reg) begin
            for (int i = 0; i < NL; i++) begin
                if (dp_addr_reg == A_GAIN_BASE + 8'(4 * i)) begin
                    gain_reg[i] <= hwdata[GAIN_W-1:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/wocr_pkg.sv
`default_nettype none
package wocr_pkg;
    localparam int SMP_W = 16;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 14;
    localparam int LEN_W = 16;
    localparam int MAX_CORES = 4;
    // Per-core route field of a play command
    localparam int R_W1_PRES = 0;
    localparam int R_W1_SEL = 1;
    localparam int R_W2_PRES = 3;
    localparam int R_W2_SEL = 4;
    localparam int ROUTE_W = 6;
    // Command word layout
    localparam int C_ROUTE = 0;
    localparam int C_LEN = ROUTE_W * MAX_CORES;
    localparam int C_WAIT = C_LEN + LEN_W;
    localparam int C_GRP = C_WAIT + 1;
    localparam int CMD_W = C_GRP + 2;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 3;
    // Grouping codes
    localparam logic [1:0] GRP_1X8 = 2'h0;
    localparam logic [1:0] GRP_2X4 = 2'h1;
    localparam logic [1:0] GRP_4X2 = 2'h2;
    localparam logic [1:0] GRP_RESET = GRP_4X2;
    // Pair-local output mask bits
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h0;
    // Register map (byte addresses)
    localparam logic [7:0] A_GROUPING = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_DROPS = 8'h08;
    localparam logic [7:0] A_GAIN_BASE = 8'h10;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 16'h4000;
    localparam int ST_WAIT_POS = 4;
    localparam int ST_GRP_POS = 8;
    typedef enum logic [1:0] {G_IDLE, G_WAIT, G_PLAY} wocr_gstate_t;
endpackage
`default_nettype wire

//--- logic/wocr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module wocr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("wocr_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wptr_reg;
    logic [AW:0] rptr_reg;
    logic push;
    logic pop;

    assign out_valid = wptr_reg != rptr_reg;
    assign in_ready = (wptr_reg[AW] == rptr_reg[AW]) ||
                      (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rptr_reg[AW-1:0]];

    always_ff @(posedge hclk) begin
        if (push) begin
            mem_reg[wptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/wocr_core_router.sv
`timescale 1ns/100ps
`default_nettype none
module wocr_core_router
    import wocr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [wocr_pkg::SMP_W-1:0] l1_smp,
    input wire logic [wocr_pkg::SMP_W-1:0] l2_smp,
    input wire logic [wocr_pkg::GAIN_W-1:0] l1_gain,
    input wire logic [wocr_pkg::GAIN_W-1:0] l2_gain,
    input wire logic [1:0] l1_mask,
    input wire logic [1:0] l2_mask,
    output logic [wocr_pkg::SMP_W-1:0] out_a,
    output logic [wocr_pkg::SMP_W-1:0] out_b
);
    localparam int PW = SMP_W + GAIN_W;
    localparam logic signed [PW:0] SMAX = (PW + 1)'(2 ** (SMP_W - 1) - 1);
    localparam logic signed [PW:0] SMIN = -(PW + 1)'(2 ** (SMP_W - 1));

    logic signed [PW-1:0] s1;
    logic signed [PW-1:0] s2;
    logic signed [PW:0] sum_a;
    logic signed [PW:0] sum_b;

    function automatic logic [SMP_W-1:0] sat(input logic signed [PW:0] v);
        if (v > SMAX) begin
            return SMAX[SMP_W-1:0];
        end else if (v < SMIN) begin
            return SMIN[SMP_W-1:0];
        end
        return v[SMP_W-1:0];
    endfunction

    always_comb begin
        // Gain follows the producing line, not the destination
        s1 = ($signed(l1_smp) * $signed(l1_gain)) >>> GAIN_FRAC;
        s2 = ($signed(l2_smp) * $signed(l2_gain)) >>> GAIN_FRAC;
        sum_a = '0;
        sum_b = '0;
        // Lines selecting the same output are summed
        if (l1_mask[0]) sum_a = sum_a + s1;
        if (l2_mask[0]) sum_a = sum_a + s2;
        if (l1_mask[1]) sum_b = sum_b + s1;
        if (l2_mask[1]) sum_b = sum_b + s2;
    end

    // Undriven outputs fall to zero through the empty sums
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_a <= '0;
            out_b <= '0;
        end else begin
            out_a <= sat(sum_a);
            out_b <= sat(sum_b);
        end
    end
endmodule
`default_nettype wire

//--- verif/wocr_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module wocr_top_monitor #(
    parameter int NUM_CORES = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic cmd_ready,
    input wire logic [NUM_CORES*2*wocr_pkg::SMP_W-1:0] line_smp,
    input wire logic [NUM_CORES-1:0] core_playing,
    input wire logic [NUM_CORES*2*wocr_pkg::SMP_W-1:0] wave_out
);
    import wocr_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_take;
    logic wr_take;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_fast: assert property (wr_take |=> hreadyout)
        else $error("write data phase stalled");
    a_ready_idle: assert property (!$past(rd_take) |-> hreadyout)
        else $error("hreadyout low without a read");
    a_rdata_hold: assert property (!$past(rd_take) && !$past(rd_take, 2)
        && !$past(rd_take, 3) |-> $stable(hrdata))
        else $error("read data changed outside a read");
    a_start_clean: assert property ($rose(hresetn)
        |-> cmd_ready && core_playing == '0)
        else $error("not idle after reset");
    for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
        a_idle_zero: assert property (
            !core_playing[c] && !$past(core_playing[c])
            |-> wave_out[c*32+:32] == '0)
            else $error("idle output pair not zero");
        a_pair_isolate: assert property (
            $past(line_smp[c*32+:32]) == '0
            && $past(line_smp[c*32+:32], 2) == '0
            |-> wave_out[c*32+:32] == '0)
            else $error("output pair fed by a foreign core");
    end
    c_read: cover property (rd_take ##2 hreadyout);
    c_full: cover property (!cmd_ready);
    c_play: cover property ($rose(core_playing[0]));
    c_quad: cover property ($rose(core_playing[1:0] == 2'h3));
endmodule
bind wocr_top wocr_top_monitor #(.NUM_CORES(NUM_CORES)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cmd_ready(cmd_ready),
    .line_smp(line_smp), .core_playing(core_playing), .wave_out(wave_out)
);
`default_nettype wire

//--- verif/wocr_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module wocr_seq_model #(
    parameter int NUM_CORES = 4
) (
    input wire logic hclk,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [wocr_pkg::CMD_W-1:0] cmd_data,
    output logic [NUM_CORES*2*wocr_pkg::SMP_W-1:0] line_smp
);
    import wocr_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd_data = '0;
        line_smp = '0;
    end
    // Per core: line 1 in the low half, line 2 in the high half
    task automatic put_smp(input logic [NUM_CORES*32-1:0] s);
        @(posedge hclk);
        line_smp <= s;
    endtask
    // Idle cycles first, then hold the command until the FIFO takes it
    task automatic send(input logic [CMD_W-1:0] c, input int gap);
        repeat (gap + 1) @(posedge hclk);
        cmd_valid <= 1'b1;
        cmd_data <= c;
        do @(posedge hclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        cmd_data <= ~c;
    endtask
endmodule
`default_nettype wire

//--- verif/wave_output_channel_routing_test.sv
`timescale 1ns/100ps
`default_nettype none
module wave_output_channel_routing_test;
    import wocr_pkg::*;
    localparam int NC = 4;
    localparam logic [5:0] TBL [8] = '{6'h09, 6'h05, 6'h08, 6'h07,
        6'h1B, 6'h3F, 6'h18, 6'h00};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic hreadyout;
    logic hresp;
    logic cmd_valid;
    logic cmd_ready;
    logic [31:0] hrdata;
    logic [CMD_W-1:0] cmd_data;
    logic [NC-1:0] trig_in = '0;
    logic [NC-1:0] core_playing;
    logic [NC*32-1:0] line_smp;
    logic [NC*32-1:0] wave_out;
    logic [15:0] g [8];
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    always #20 hclk = ~hclk;
    wocr_top #(.NUM_CORES(NC)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .trig_in(trig_in), .line_smp(line_smp),
        .core_playing(core_playing), .wave_out(wave_out));
    wocr_seq_model #(.NUM_CORES(NC)) seq (.hclk(hclk),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_data(cmd_data), .line_smp(line_smp));
    task automatic end_sim;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // Gain applies per producing line; sums clip to 16 bits
    function automatic logic [15:0] expect_out(logic [5:0] r,
        logic [31:0] s, logic [15:0] ga, logic [15:0] gb, int o);
        logic [1:0] m1;
        logic [1:0] m2;
        int acc;
        m1 = !r[0] ? SEL_NONE : (r[2:1] == 2'h0 ? SEL_A : r[2:1]);
        m2 = !r[3] ? SEL_NONE : (r[5:4] == 2'h0 ? SEL_B : r[5:4]);
        acc = 0;
        if (m1[o]) acc += (int'($signed(s[15:0])) * int'($signed(ga))) >>> 14;
        if (m2[o]) acc += (int'($signed(s[31:16])) * int'($signed(gb))) >>> 14;
        if (acc > 32767) acc = 32767;
        if (acc < -32768) acc = -32768;
        return acc[15:0];
    endfunction
    task automatic play(input logic [23:0] r, input logic [NC*32-1:0] s,
        input logic [1:0] grp, input logic [NC-1:0] m, input logic w);
        int n;
        seq.put_smp(s);
        seq.send({grp, w, 16'h0008, r}, $urandom_range(0, 3));
        if (w) begin
            repeat (6) @(negedge hclk);
            chk(core_playing & m, 32'h0);
            @(posedge hclk);
            trig_in[grp] <= 1'b1;
        end
        n = 0;
        while (core_playing === '0 && n < 40) begin
            @(negedge hclk);
            n++;
        end
        chk(core_playing, m);
        repeat (2) @(negedge hclk);
        for (int c = 0; c < NC; c++) begin
            for (int o = 0; o < 2; o++) begin
                chk(wave_out[c*32+o*16+:16], m[c] ? expect_out(r[c*6+:6],
                    s[c*32+:32], g[2*c], g[2*c+1], o) : 16'h0);
            end
        end
        while (core_playing !== '0) @(negedge hclk);
        @(posedge hclk);
        trig_in <= '0;
        repeat (2) @(negedge hclk);
    endtask
    initial begin
        int c;
        int k;
        void'($urandom(45471));
        for (int i = 0; i < 8; i++) g[i] = GAIN_RESET;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(A_GROUPING, {30'h0, GRP_RESET});
        rd(A_STATUS, 32'h00000200);
        rd(A_GAIN_BASE, 32'h00004000);
        rd(8'h0C, 32'h0);
        for (int gi = 0; gi < 3; gi++) begin
            wr(A_GROUPING, gi);
            rd(A_GROUPING, gi);
            play({4{6'h09}}, {$urandom, 32'h0, $urandom, $urandom}, 2'h0,
                gi == 0 ? 4'hF : (gi == 1 ? 4'h3 : 4'h1), 1'b0);
        end
        wr(A_GROUPING, 32'h3);
        rd(A_GROUPING, 32'h2);
        for (int i = 0; i < 8; i++) begin
            play({12'h0, TBL[i], 6'h0}, {64'h0, 32'h60007000, 32'h0},
                2'h1, 4'h2, 1'b0);
        end
        wr(A_GAIN_BASE, 32'h2000);
        g[0] = 16'h2000;
        wr(A_GAIN_BASE + 8'h04, 32'hC000);
        g[1] = 16'hC000;
        rd(A_GAIN_BASE + 8'h04, 32'h0000C000);
        play({18'h0, 6'h05}, {96'h0, 32'h12344000}, 2'h0, 4'h1, 1'b0);
        play({6'h09, 18'h0}, {32'h55556666, 96'h0}, 2'h3, 4'h8, 1'b1);
        repeat (12) begin
            k = $urandom_range(0, 7);
            g[k] = $urandom;
            wr(A_GAIN_BASE + 8'(k * 4), {16'h0, g[k]});
            c = $urandom_range(0, NC - 1);
            play($urandom, {$urandom, $urandom, $urandom, $urandom},
                c[1:0], 4'h1 << c, 1'b0);
        end
        for (int i = 0; i < 5; i++) seq.send({3'h0, 16'h0028, 24'h9}, 1);
        @(negedge hclk);
        chk(cmd_ready, 32'h0);
        wr(A_GROUPING, 32'h0);
        rd(A_GROUPING, 32'h2);
        rd(A_STATUS, 32'h00000201);
        // Five 40-sample commands of one group drain in about 210 cycles
        repeat (240) @(negedge hclk);
        chk(cmd_ready, 32'h1);
        chk(core_playing, 32'h0);
        // Bad group index is dropped, zero length plays nothing
        wr(A_GROUPING, {30'h0, GRP_2X4});
        seq.send({2'h3, 1'b0, 16'h0008, 24'h9}, 0);
        seq.send({2'h0, 1'b0, 16'h0000, 24'h9}, 0);
        rd(A_DROPS, 32'h1);
        chk(core_playing, 32'h0);
        rd(A_STATUS, 32'h00000100);
        end_sim;
    end
endmodule
`default_nettype wire
